// [rtl/aelc_defs.svh]
`ifndef AELC_DEFS_SVH
`define AELC_DEFS_SVH

// register byte offsets
`define AELC_OFS_GAIN        6'h00
`define AELC_OFS_ENERGY      6'h04
`define AELC_OFS_DIVIDER     6'h08
`define AELC_OFS_READ_CLEAR  6'h0C
`define AELC_OFS_HALF_CYCLES 6'h10
`define AELC_OFS_LC_APPARENT 6'h14
`define AELC_OFS_LC_REACTIVE 6'h18
`define AELC_OFS_WAVE_SELECT 6'h1C
`define AELC_OFS_STATUS3     6'h20
`define AELC_OFS_STATUS2     6'h24
`define AELC_OFS_ENABLE2     6'h28
`define AELC_OFS_ENABLE3     6'h2C
`define AELC_OFS_WAVE_DATA   6'h30
`define AELC_OFS_CF_MODE     6'h34

// field positions
`define AELC_ST3_CYCLE_END   0
`define AELC_ST3_WAVE_READY  1
`define AELC_EN3_CYCLE_END   0
`define AELC_EN3_WAVE_SAMPLE 1
`define AELC_EN3_WAVE_READY  2
`define AELC_ST2_HALF_FULL   0
`define AELC_ST2_OVERFLOW    1
`define AELC_WSEL_SRC_LSB    0
`define AELC_WSEL_RATE_LSB   2
`define AELC_WSRC_APPARENT   2'h3

// reset values
`define AELC_RST_HALF_CYCLES 16'hFFFF
`define AELC_RST_GAIN        12'h000
`define AELC_RST_DIVIDER     8'h00

// timing
`define AELC_CLK_HZ          50000000
`define AELC_ACC_PERIOD      5
`define AELC_WAVE_SPS        27900
`define AELC_CF_LOW_MS       90

`endif

// [rtl/aelc_pkg.sv]
package aelc_pkg;

  typedef enum logic [0:0] {
    AELC_LC_WAIT = 1'b0,
    AELC_LC_RUN  = 1'b1
  } aelc_lc_state_t;

  typedef logic [23:0] aelc_word24_t;

endpackage

// [rtl/aelc_top.sv]
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "aelc_defs.svh"
// Overview of operation
// - line-cycle reactive energy sums reactive power over programmed half cycles
// - cycle end sets status flag; enabled flag holds pending interrupt until cleared
// - next accumulation starts at cycle end; result overwritten even if unread
// - writing half-cycle count clears reactive result; restart at next zero crossing
// - writing half-cycle count clears apparent result; restart at next zero crossing
// - line reactive uses reactive energy path, same lsb weight
// - line-cycle apparent accumulation always runs, no enable bit
// - apparent power sampled into waveform register at selectable rate
// - apparent power scaled by one plus signed 12-bit gain over 4096
// - apparent power is vrms times irms, no offset correction
// - wide accumulator, upper 24 bits form apparent energy register
// - one sample added every five clock periods
// - accumulation is a signed addition
// - 8-bit unsigned divider, zero acts as one
// - read-to-clear register returns energy then clears it
// - unsigned energy raises enabled half-full and overflow interrupts
// - half-full judged on full 24-bit unsigned value
// - pulse output follows gain-calibrated power, optionally current rms
// - energy pulse output is active low
// - half-cycle count is unsigned 16 bits
// - apparent and reactive line results cover same half-cycle interval
// - first cycle end after count write gives a valid result
module aelc_top
  import aelc_pkg::*;
#(
  parameter int unsigned CF_LOW_CYC = `AELC_CF_LOW_MS * (`AELC_CLK_HZ / 1000)
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  input  wire logic [5:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  output logic      [31:0]        readdata,
  output logic                    waitrequest,
  input  wire logic [23:0]        vrms,
  input  wire logic [23:0]        irms,
  input  wire logic signed [23:0] reactive_power,
  input  wire logic               zero_cross,
  output logic                    irq_pending,
  output logic                    cf_pulse_n
);
  localparam int unsigned WAVE_DIV = `AELC_CLK_HZ / `AELC_WAVE_SPS;
  aelc_lc_state_t        lc_state_reg;
  logic [2:0]            tick_cnt_reg;
  logic                  tick;
  logic [11:0]           gain_reg;
  logic [7:0]            divider_reg;
  logic [15:0]           half_cycles_reg;
  logic [3:0]            wave_sel_reg;
  logic [1:0]            status3_reg;
  logic [1:0]            status2_reg;
  logic [1:0]            enable2_reg;
  logic [2:0]            enable3_reg;
  logic                  cf_irms_reg;
  logic [23:0]           wave_data_reg;
  aelc_word24_t          energy_reg;
  aelc_word24_t          energy_next;
  logic [23:0]           app_res_reg;
  logic [7:0]            div_cnt_reg;
  logic [23:0]           var_res_reg;
  aelc_word24_t          lc_app_acc_reg;
  aelc_word24_t          lc_var_acc_reg;
  aelc_word24_t          lc_app_reg;
  aelc_word24_t          lc_var_reg;
  logic [15:0]           hc_cnt_reg;
  logic [10:0]           wave_base_reg;
  logic [2:0]            wave_sub_reg;
  logic [23:0]           cf_res_reg;
  logic [22:0]           cf_low_reg;
  logic [31:0]           rd_mux;
  logic                  bus_req;
  logic                  wr_done;
  logic                  rd_done;
  logic                  hc_write;
  logic [47:0]           vi_product;
  logic signed [22:0]    ap_raw;
  logic signed [34:0]    ap_gain_prod;
  logic signed [23:0]    ap_cal;
  logic signed [25:0]    app_sum;
  logic                  app_carry;
  logic                  app_borrow;
  logic [7:0]            div_eff;
  logic                  e_up;
  logic                  e_down;
  logic signed [25:0]    var_sum;
  logic                  var_carry;
  logic                  var_borrow;
  logic [15:0]           hc_eff;
  logic                  cycle_end;
  logic                  wave_tick;
  logic [2:0]            wave_sub_max;
  logic [23:0]           cf_src;
  logic [24:0]           cf_sum;
  // bus: request seen with waitrequest high, answered one cycle later
  assign bus_req  = read | write;
  assign wr_done  = write & ~waitrequest;
  assign rd_done  = read & ~waitrequest;
  assign hc_write = wr_done & (address == `AELC_OFS_HALF_CYCLES);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~(bus_req & waitrequest);
    end
  end

  always_comb begin
    unique case (address)
      `AELC_OFS_GAIN:        rd_mux = {20'h00000, gain_reg};
      `AELC_OFS_ENERGY:      rd_mux = {8'h00, energy_reg};
      `AELC_OFS_DIVIDER:     rd_mux = {24'h000000, divider_reg};
      `AELC_OFS_READ_CLEAR:  rd_mux = {8'h00, energy_reg};
      `AELC_OFS_HALF_CYCLES: rd_mux = {16'h0000, half_cycles_reg};
      `AELC_OFS_LC_APPARENT: rd_mux = {8'h00, lc_app_reg};
      `AELC_OFS_LC_REACTIVE: rd_mux = {8'h00, lc_var_reg};
      `AELC_OFS_WAVE_SELECT: rd_mux = {28'h0000000, wave_sel_reg};
      `AELC_OFS_STATUS3:     rd_mux = {30'h00000000, status3_reg};
      `AELC_OFS_STATUS2:     rd_mux = {30'h00000000, status2_reg};
      `AELC_OFS_ENABLE2:     rd_mux = {30'h00000000, enable2_reg};
      `AELC_OFS_ENABLE3:     rd_mux = {29'h00000000, enable3_reg};
      `AELC_OFS_WAVE_DATA:   rd_mux = {8'h00, wave_data_reg};
      `AELC_OFS_CF_MODE:     rd_mux = {31'h00000000, cf_irms_reg};
      default:               rd_mux = 32'h00000000;
    endcase
  end

  // data latched on the first cycle so it is stable when waitrequest drops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h00000000;
    end else if (read & waitrequest) begin
      readdata <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_reg        <= `AELC_RST_GAIN;
      divider_reg     <= `AELC_RST_DIVIDER;
      half_cycles_reg <= `AELC_RST_HALF_CYCLES;
      wave_sel_reg    <= 4'h0;
      enable2_reg     <= 2'h0;
      enable3_reg     <= 3'h0;
      cf_irms_reg     <= 1'b0;
    end else if (wr_done) begin
      unique case (address)
        `AELC_OFS_GAIN:        gain_reg <= writedata[11:0];
        `AELC_OFS_DIVIDER:     divider_reg <= writedata[7:0];
        `AELC_OFS_HALF_CYCLES: half_cycles_reg <= writedata[15:0];
        `AELC_OFS_WAVE_SELECT: wave_sel_reg <= writedata[3:0];
        `AELC_OFS_ENABLE2:     enable2_reg <= writedata[1:0];
        `AELC_OFS_ENABLE3:     enable3_reg <= writedata[2:0];
        `AELC_OFS_CF_MODE:     cf_irms_reg <= writedata[0];
        default: ;
      endcase
    end
  end

  // accumulation strobe every five clocks
  assign tick = (tick_cnt_reg == 3'(`AELC_ACC_PERIOD - 1));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 3'h0;
    end else begin
      tick_cnt_reg <= tick ? 3'h0 : tick_cnt_reg + 3'h1;
    end
  end

  // apparent power and gain; top bits kept so one sample gives at most one carry
  assign vi_product   = vrms * irms;
  assign ap_raw       = $signed({1'b0, vi_product[47:26]});
  assign ap_gain_prod = ap_raw * $signed(gain_reg);
  assign ap_cal       = 24'(ap_raw + (ap_gain_prod >>> 12));

  // residue below the register lsb, signed add with carry or borrow
  assign app_sum    = $signed({2'b00, app_res_reg}) + 26'(ap_cal);
  assign app_carry  = tick & ~app_sum[25] & app_sum[24];
  assign app_borrow = tick & app_sum[25];
  assign div_eff    = (divider_reg == 8'h00) ? 8'h01 : divider_reg;
  assign e_up       = app_carry & (div_cnt_reg >= div_eff - 8'h01);
  assign e_down     = app_borrow & (div_cnt_reg == 8'h00);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      app_res_reg <= 24'h000000;
      div_cnt_reg <= 8'h00;
    end else if (tick) begin
      app_res_reg <= app_sum[23:0];
      if (app_carry) begin
        div_cnt_reg <= e_up ? 8'h00 : div_cnt_reg + 8'h01;
      end else if (app_borrow) begin
        div_cnt_reg <= e_down ? div_eff - 8'h01 : div_cnt_reg - 8'h01;
      end
    end
  end

  // the clear takes away only what was returned, so steps after the latch survive
  always_comb begin
    energy_next = energy_reg;
    if (rd_done && address == `AELC_OFS_READ_CLEAR) begin
      energy_next = energy_reg - readdata[23:0];
    end
    if (e_up) begin
      energy_next = energy_next + 24'h000001;
    end else if (e_down) begin
      energy_next = energy_next - 24'h000001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      energy_reg <= 24'h000000;
    end else begin
      energy_reg <= energy_next;
    end
  end

  // half-full and overflow flags, write zero clears, a new event wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status2_reg <= 2'h0;
    end else begin
      if (wr_done && address == `AELC_OFS_STATUS2) begin
        status2_reg <= status2_reg & writedata[1:0];
      end
      if (e_up && energy_reg == 24'h7FFFFF) begin
        status2_reg[`AELC_ST2_HALF_FULL] <= 1'b1;
      end
      if (e_up && energy_reg == 24'hFFFFFF) begin
        status2_reg[`AELC_ST2_OVERFLOW] <= 1'b1;
      end
    end
  end

  // reactive residue shares the reactive energy path weight
  assign var_sum    = $signed({2'b00, var_res_reg}) + 26'(reactive_power);
  assign var_carry  = tick & ~var_sum[25] & var_sum[24];
  assign var_borrow = tick & var_sum[25];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      var_res_reg <= 24'h000000;
    end else if (tick) begin
      var_res_reg <= var_sum[23:0];
    end
  end

  // line-cycle timing
  assign hc_eff    = (half_cycles_reg == 16'h0000) ? 16'h0001 : half_cycles_reg;
  assign cycle_end = (lc_state_reg == AELC_LC_RUN) & zero_cross & ~hc_write
                     & (hc_cnt_reg + 16'h0001 >= hc_eff);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lc_state_reg <= AELC_LC_WAIT;
      hc_cnt_reg   <= 16'h0000;
    end else if (hc_write) begin
      lc_state_reg <= AELC_LC_WAIT;
      hc_cnt_reg   <= 16'h0000;
    end else begin
      unique case (lc_state_reg)
        AELC_LC_WAIT: begin
          if (zero_cross) begin
            lc_state_reg <= AELC_LC_RUN;
            hc_cnt_reg   <= 16'h0000;
          end
        end
        AELC_LC_RUN: begin
          if (cycle_end) begin
            hc_cnt_reg <= 16'h0000;
          end else if (zero_cross) begin
            hc_cnt_reg <= hc_cnt_reg + 16'h0001;
          end
        end
      endcase
    end
  end

  // both sums open and close on the same edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lc_app_acc_reg <= 24'h000000;
      lc_var_acc_reg <= 24'h000000;
    end else if (hc_write || lc_state_reg == AELC_LC_WAIT || cycle_end) begin
      lc_app_acc_reg <= 24'h000000;
      lc_var_acc_reg <= 24'h000000;
    end else begin
      if (e_up) begin
        lc_app_acc_reg <= lc_app_acc_reg + 24'h000001;
      end else if (e_down) begin
        lc_app_acc_reg <= lc_app_acc_reg - 24'h000001;
      end
      if (var_carry) begin
        lc_var_acc_reg <= lc_var_acc_reg + 24'h000001;
      end else if (var_borrow) begin
        lc_var_acc_reg <= lc_var_acc_reg - 24'h000001;
      end
    end
  end

  // the in-flight sample step at cycle end is counted into the result
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lc_app_reg <= 24'h000000;
      lc_var_reg <= 24'h000000;
    end else if (hc_write) begin
      lc_app_reg <= 24'h000000;
      lc_var_reg <= 24'h000000;
    end else if (cycle_end) begin
      lc_app_reg <= lc_app_acc_reg + {23'h000000, e_up} - {23'h000000, e_down};
      lc_var_reg <= lc_var_acc_reg + {23'h000000, var_carry}
                    - {23'h000000, var_borrow};
    end
  end

  // waveform sampling at base rate divided by 1, 2, 4 or 8
  assign wave_sub_max = 3'((4'h1 << wave_sel_reg[`AELC_WSEL_RATE_LSB +: 2]) - 4'h1);
  assign wave_tick    = (wave_base_reg == 11'(WAVE_DIV - 1)) && (wave_sub_reg >= wave_sub_max);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_base_reg <= 11'h000;
      wave_sub_reg  <= 3'h0;
    end else if (wave_base_reg == 11'(WAVE_DIV - 1)) begin
      wave_base_reg <= 11'h000;
      wave_sub_reg  <= wave_tick ? 3'h0 : wave_sub_reg + 3'h1;
    end else begin
      wave_base_reg <= wave_base_reg + 11'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_data_reg <= 24'h000000;
    end else if (wave_tick && enable3_reg[`AELC_EN3_WAVE_SAMPLE]
                 && wave_sel_reg[`AELC_WSEL_SRC_LSB +: 2] == `AELC_WSRC_APPARENT) begin
      wave_data_reg <= ap_cal;
    end
  end

  // status 3: write zero clears, hardware set wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status3_reg <= 2'h0;
    end else begin
      if (wr_done && address == `AELC_OFS_STATUS3) begin
        status3_reg <= status3_reg & writedata[1:0];
      end
      if (cycle_end) begin
        status3_reg[`AELC_ST3_CYCLE_END] <= 1'b1;
      end
      if (wave_tick && enable3_reg[`AELC_EN3_WAVE_SAMPLE]
          && wave_sel_reg[`AELC_WSEL_SRC_LSB +: 2] == `AELC_WSRC_APPARENT) begin
        status3_reg[`AELC_ST3_WAVE_READY] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pending <= 1'b0;
    end else begin
      irq_pending <= (status3_reg[`AELC_ST3_CYCLE_END] & enable3_reg[`AELC_EN3_CYCLE_END])
                     | (status3_reg[`AELC_ST3_WAVE_READY] & enable3_reg[`AELC_EN3_WAVE_READY])
                     | (|(status2_reg & enable2_reg));
    end
  end

  // simple frequency converter; low time keeps a visible led flash
  assign cf_src = cf_irms_reg ? irms : {1'b0, ap_cal[23] ? 23'h000000 : ap_cal[22:0]};
  assign cf_sum = {1'b0, cf_res_reg} + {1'b0, cf_src};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cf_res_reg <= 24'h000000;
      cf_low_reg <= 23'h000000;
      cf_pulse_n <= 1'b1;
    end else begin
      if (tick) begin
        cf_res_reg <= cf_sum[23:0];
      end
      if (tick && cf_sum[24]) begin
        cf_low_reg <= 23'(CF_LOW_CYC);
        cf_pulse_n <= 1'b0;
      end else if (cf_low_reg != 23'h000000) begin
        cf_low_reg <= cf_low_reg - 23'h000001;
        cf_pulse_n <= (cf_low_reg == 23'h000001);
      end else begin
        cf_pulse_n <= 1'b1;
      end
    end
  end

endmodule // aelc_top

// [test/aelc_top_monitor.sv]
`timescale 1ns/1ps
`include "aelc_defs.svh"
module aelc_top_monitor #(
  parameter int unsigned CF_LOW_CYC = 8
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        irq_pending,
  input wire logic        cf_pulse_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // length of the current low phase of the pulse output
  logic [31:0] low_cnt_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_reg <= '0;
    end else if (!cf_pulse_n) begin
      low_cnt_reg <= low_cnt_reg + 32'h1;
    end else begin
      low_cnt_reg <= '0;
    end
  end

  sequence bus_take;
    (read || write) && waitrequest;
  endsequence
  sequence bus_done;
    !waitrequest ##1 waitrequest;
  endsequence

  wait_one_a: assert property (bus_take |=> bus_done)
    else $error("waitrequest not low for exactly one cycle");
  idle_wait_a: assert property (!(read || write) |=> waitrequest)
    else $error("waitrequest dropped without a request");
  unmapped_zero_a: assert property (
    bus_take and (read && address > `AELC_OFS_CF_MODE) |=> readdata == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (bus_take and read |=> readdata[31:24] == 8'h00)
    else $error("upper read bits not zero");
  rd_hold_a: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("readdata changed without a read");
  cf_len_a: assert property ($rose(cf_pulse_n) |-> low_cnt_reg == CF_LOW_CYC)
    else $error("pulse low phase has wrong length");
  cf_max_a: assert property (low_cnt_reg <= CF_LOW_CYC)
    else $error("pulse low phase too long");
  irq_clear_a: assert property ($fell(irq_pending) |-> $past(write) || $past(write, 2))
    else $error("interrupt dropped without a clearing write");
endmodule // aelc_top_monitor

bind aelc_top aelc_top_monitor #(.CF_LOW_CYC(CF_LOW_CYC)) mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .irq_pending(irq_pending),
  .cf_pulse_n(cf_pulse_n));

// [test/aelc_line_src.sv]
`timescale 1ns/1ps
module aelc_line_src #(
  parameter int unsigned HALF_CYC = 100
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  output logic      zero_cross
);
  // fixed half period: a real line drifts, this keeps spans exact
  logic [15:0] cnt_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      zero_cross <= 1'b0;
    end else if (cnt_reg == 16'(HALF_CYC - 1)) begin
      cnt_reg <= '0;
      zero_cross <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h1;
      zero_cross <= 1'b0;
    end
  end
endmodule // aelc_line_src

// [test/aelc_top_tb.sv]
`timescale 1ns/1ps
`include "aelc_defs.svh"
module aelc_top_tb
  import aelc_pkg::*;
;
  logic               ref_clk        = 1'b0;
  logic               rst_n          = 1'b0;
  logic [5:0]         address        = 6'h00;
  logic               read           = 1'b0;
  logic               write          = 1'b0;
  logic [31:0]        writedata      = 32'h0;
  logic [23:0]        vrms           = 24'h800000;
  logic [23:0]        irms           = 24'h800000;
  logic signed [23:0] reactive_power = 24'sh100000;
  logic [31:0]        readdata;
  logic               waitrequest;
  logic               irq_pending;
  logic               cf_pulse_n;
  logic               zero_cross;
  logic [31:0]        rd;
  int                 num_errors     = 0;
  int                 compares       = 0;
  int                 cf_lows        = 0;

  always #10 ref_clk = ~ref_clk;

  aelc_top #(.CF_LOW_CYC(8)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .vrms(vrms), .irms(irms), .reactive_power(reactive_power), .zero_cross(zero_cross),
    .irq_pending(irq_pending), .cf_pulse_n(cf_pulse_n));
  aelc_line_src #(.HALF_CYC(100)) line (
    .ref_clk(ref_clk), .rst_n(rst_n), .zero_cross(zero_cross));

  always @(posedge ref_clk) if (cf_pulse_n === 1'b0) cf_lows++;

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                     input logic [31:0] got);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h..%h seen %h", nm, lo, hi, got);
    end
  endtask

  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] lo,
                      input logic [31:0] hi);
    bus(1'b0, a, 32'h0);
    chk(nm, lo, hi, rd);
  endtask

  // clear, try to overwrite the read-only copy, then let 1600 cycles accumulate
  task automatic span(input string nm, input logic [31:0] lo, input logic [31:0] hi);
    bus(1'b0, `AELC_OFS_READ_CLEAR, 32'h0);
    bus(1'b1, `AELC_OFS_ENERGY, 32'h00FFFFFF);
    repeat (1600) @(posedge ref_clk);
    rchk(nm, `AELC_OFS_ENERGY, lo, hi);
  endtask

  task automatic results;
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    results();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rchk("gain", `AELC_OFS_GAIN, 32'h0, 32'h0);
    rchk("divider", `AELC_OFS_DIVIDER, 32'h0, 32'h0);
    rchk("half_cycles", `AELC_OFS_HALF_CYCLES, 32'hFFFF, 32'hFFFF);
    rchk("lc_apparent", `AELC_OFS_LC_APPARENT, 32'h0, 32'h0);
    rchk("unmapped", 6'h3C, 32'h0, 32'h0);
    bus(1'b1, `AELC_OFS_HALF_CYCLES, 32'h00012345);
    rchk("half_cycles_w", `AELC_OFS_HALF_CYCLES, 32'h2345, 32'h2345);
    bus(1'b1, `AELC_OFS_ENABLE2, 32'h3);
    rchk("enable2", `AELC_OFS_ENABLE2, 32'h3, 32'h3);
    rchk("status2", `AELC_OFS_STATUS2, 32'h0, 32'h0);
    bus(1'b1, `AELC_OFS_GAIN, 32'hFFFFF800);
    rchk("gain_w", `AELC_OFS_GAIN, 32'h800, 32'h800);
    // gain of minus one half halves the rate
    span("energy_gain", 32'd9, 32'd11);
    bus(1'b1, `AELC_OFS_GAIN, 32'h0);
    span("energy", 32'd19, 32'd21);
    bus(1'b1, `AELC_OFS_DIVIDER, 32'h2);
    span("energy_div", 32'd9, 32'd11);
    rchk("read_clear", `AELC_OFS_READ_CLEAR, 32'd9, 32'd12);
    rchk("cleared", `AELC_OFS_ENERGY, 32'd0, 32'd1);
    bus(1'b1, `AELC_OFS_DIVIDER, 32'h0);
    bus(1'b1, `AELC_OFS_ENABLE3, 32'h1);
    @(posedge zero_cross);
    // start crossing at +100, end four crossings later at +500
    bus(1'b1, `AELC_OFS_HALF_CYCLES, 32'h4);
    repeat (430) @(posedge ref_clk);
    bus(1'b0, `AELC_OFS_STATUS3, 32'h0);
    chk("early_end", 32'h0, 32'h0, rd & 32'h1);
    repeat (100) @(posedge ref_clk);
    bus(1'b0, `AELC_OFS_STATUS3, 32'h0);
    chk("cycle_end", 32'h1, 32'h1, rd & 32'h1);
    chk("irq_set", 32'h1, 32'h1, 32'(irq_pending));
    rchk("lc_app_val", `AELC_OFS_LC_APPARENT, 32'd4, 32'd6);
    rchk("lc_reac_val", `AELC_OFS_LC_REACTIVE, 32'd4, 32'd6);
    bus(1'b1, `AELC_OFS_STATUS3, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("irq_clear", 32'h0, 32'h0, 32'(irq_pending));
    repeat (400) @(posedge ref_clk);
    bus(1'b0, `AELC_OFS_STATUS3, 32'h0);
    chk("next_end", 32'h1, 32'h1, rd & 32'h1);
    bus(1'b1, `AELC_OFS_HALF_CYCLES, 32'h4);
    rchk("lc_app_clr", `AELC_OFS_LC_APPARENT, 32'h0, 32'h0);
    rchk("lc_reac_clr", `AELC_OFS_LC_REACTIVE, 32'h0, 32'h0);
    bus(1'b1, `AELC_OFS_WAVE_SELECT, 32'h3);
    bus(1'b1, `AELC_OFS_ENABLE3, 32'h2);
    repeat (2000) @(posedge ref_clk);
    bus(1'b0, `AELC_OFS_STATUS3, 32'h0);
    chk("wave_ready", 32'h2, 32'h2, rd & 32'h2);
    rchk("wave_data", `AELC_OFS_WAVE_DATA, 32'h100000, 32'h100000);
    chk("cf_low", 32'h1, 32'hFFFFFFFF, 32'(cf_lows));
    bus(1'b1, `AELC_OFS_ENABLE3, 32'h6);
    repeat (2) @(posedge ref_clk);
    chk("irq_wave", 32'h1, 32'h1, 32'(irq_pending));
    // slowest rate needs eight base periods, so nothing may land within 1900 cycles
    bus(1'b1, `AELC_OFS_WAVE_SELECT, 32'hF);
    bus(1'b1, `AELC_OFS_STATUS3, 32'h0);
    repeat (1900) @(posedge ref_clk);
    bus(1'b0, `AELC_OFS_STATUS3, 32'h0);
    chk("wave_slow", 32'h0, 32'h0, rd & 32'h2);
    // switch while the output is high, so no carry retriggers a low phase
    @(posedge cf_pulse_n);
    bus(1'b1, `AELC_OFS_CF_MODE, 32'h1);
    rchk("cf_mode", `AELC_OFS_CF_MODE, 32'h1, 32'h1);
    cf_lows = 0;
    repeat (400) @(posedge ref_clk);
    // half-scale current carries every second tick: low 8 of every 10 cycles
    chk("cf_irms", 32'h12C, 32'h154, 32'(cf_lows));
    results();
  end
endmodule // aelc_top_tb
